// ===== shared/twm_pkg.sv
/*
  Constants, register map and mode encoding for the timer waveform block.
  Assumes an APB slave with 32-bit data, one aligned word per register.
*/
package twm_pkg;
  // register byte addresses
  localparam logic [7:0] OFF_CTRL_A = 8'hB0;
  localparam logic [7:0] OFF_CTRL_B = 8'hB4;
  localparam logic [7:0] OFF_CMP_A = 8'hB8;
  localparam logic [7:0] OFF_CMP_B = 8'hBC;
  localparam logic [7:0] OFF_STATUS = 8'hC0;
  localparam logic [7:0] OFF_PORT = 8'hC4;
  // reset values, masks and counter limits
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;
  localparam logic [3:0] RST_PORT = 4'h0;
  localparam logic [7:0] CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK = 8'h09;
  localparam logic [7:0] MAX_VAL = 8'hFF;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  // field positions
  localparam int ACT_A_LO = 6;
  localparam int ACT_B_LO = 4;
  localparam int MODE_HI_BIT = 3;
  localparam int RUN_BIT = 0;
  localparam int OVF_BIT = 8;
  localparam int UP_BIT = 9;
  localparam int DIR_A_BIT = 0;
  localparam int DIR_B_BIT = 1;
  localparam int DATA_A_BIT = 2;
  localparam int DATA_B_BIT = 3;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_PHASE_FF = 3'b001,
    MODE_MATCH = 3'b010,
    MODE_FAST_FF = 3'b011,
    MODE_RSV4 = 3'b100,
    MODE_PHASE_A = 3'b101,
    MODE_RSV6 = 3'b110,
    MODE_FAST_A = 3'b111
  } twm_mode_type;
endpackage

// ===== src/twm_core.sv
/*
  8-bit timer with two compare output channels, control register A and
  the mode and run bits of control register B, reached over APB.
  Assumes pclk is the timer clock and the bus master follows APB.
*/
// Behaviour
// - nonzero A action drives pin A, except PWM code 1 without high bit
// - pin driver enabled only by direction bit
// - non-PWM A: off, toggle, clear, set
// - PWM A code 1: toggle only with high bit
// - fast PWM A: match clear/set, opposite at bottom
// - phase PWM A: up match one, down other
// - fast: compare equals TOP ignores clear/set match
// - phase: compare equals TOP acts at TOP
// - nonzero B action drives pin B
// - non-PWM B: off, toggle, clear, set
// - fast PWM B: code 1 reserved, else A
// - phase PWM B: code 1 reserved, else A
// - control A bits 3:2 read zero
// - three mode bits pick sequence, TOP, waveform
// - modes 0,2 immediate update, overflow at MAX
// - phase/fast update points, TOP sources, reserved modes
`timescale 1ns/1ps
module twm_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe
);
  logic [7:0] control_a;
  logic [7:0] control_b;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [7:0] live_a;
  logic [7:0] live_b;
  logic [7:0] count;
  logic [3:0] port_ctl;
  logic overflow_flag;
  logic count_up;
  logic oc_a;
  logic oc_b;
  logic mapped;
  logic wr;
  logic [31:0] next_prdata;
  logic [1:0] act_a;
  logic [1:0] act_b;
  twm_pkg::twm_mode_type mode;
  logic is_fast;
  logic is_phase;
  logic is_pwm;
  logic tick;
  logic [7:0] top;
  logic at_top;
  logic at_bot;
  logic ovf_evt;
  logic upd_evt;
  logic match_a;
  logic match_b;
  logic a_linked;

  assign act_a = control_a[twm_pkg::ACT_A_LO +: 2];
  assign act_b = control_a[twm_pkg::ACT_B_LO +: 2];
  assign mode = twm_pkg::twm_mode_type'({control_b[twm_pkg::MODE_HI_BIT], control_a[1:0]});
  assign is_fast = (mode == twm_pkg::MODE_FAST_FF) || (mode == twm_pkg::MODE_FAST_A);
  assign is_phase = (mode == twm_pkg::MODE_PHASE_FF) || (mode == twm_pkg::MODE_PHASE_A);
  assign is_pwm = is_fast || is_phase;
  // reserved modes hold the counter still
  assign tick = control_b[twm_pkg::RUN_BIT] && (mode != twm_pkg::MODE_RSV4)
    && (mode != twm_pkg::MODE_RSV6);
  // TOP from compare A in modes 2, 5 and 7
  assign top = (mode == twm_pkg::MODE_MATCH || mode == twm_pkg::MODE_PHASE_A
    || mode == twm_pkg::MODE_FAST_A) ? live_a : twm_pkg::MAX_VAL;
  assign at_top = (count == top);
  assign at_bot = (count == twm_pkg::BOTTOM_VAL);
  assign match_a = (count == live_a);
  assign match_b = (count == live_b);

  always_comb begin
    if (mode == twm_pkg::MODE_FAST_A) begin
      ovf_evt = at_top;
    end else if (is_phase) begin
      ovf_evt = at_bot && !count_up;
    end else begin
      ovf_evt = (count == twm_pkg::MAX_VAL);
    end
  end
  // buffered compare values reload at TOP for both PWM kinds, so fast
  // PWM sees the new value from BOTTOM on
  assign upd_evt = tick && is_pwm && at_top;

  // APB slave, zero wait states
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    mapped = 1'b1;
    next_prdata = 32'h0000_0000;
    if (paddr == twm_pkg::OFF_CTRL_A) begin
      next_prdata[7:0] = control_a & twm_pkg::CTRL_A_MASK;
    end else if (paddr == twm_pkg::OFF_CTRL_B) begin
      next_prdata[7:0] = control_b;
    end else if (paddr == twm_pkg::OFF_CMP_A) begin
      next_prdata[7:0] = compare_value_a;
    end else if (paddr == twm_pkg::OFF_CMP_B) begin
      next_prdata[7:0] = compare_value_b;
    end else if (paddr == twm_pkg::OFF_STATUS) begin
      next_prdata[7:0] = count;
      next_prdata[twm_pkg::OVF_BIT] = overflow_flag;
      next_prdata[twm_pkg::UP_BIT] = count_up;
    end else if (paddr == twm_pkg::OFF_PORT) begin
      next_prdata[3:0] = port_ctl;
    end else begin
      mapped = 1'b0;
    end
  end

  // read data is latched in the setup cycle and stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_a <= twm_pkg::RST_CTRL;
      control_b <= twm_pkg::RST_CTRL;
      compare_value_a <= twm_pkg::RST_CMP;
      compare_value_b <= twm_pkg::RST_CMP;
      port_ctl <= twm_pkg::RST_PORT;
    end else if (wr) begin
      if (paddr == twm_pkg::OFF_CTRL_A) begin
        control_a <= pwdata[7:0] & twm_pkg::CTRL_A_MASK;
      end else if (paddr == twm_pkg::OFF_CTRL_B) begin
        control_b <= pwdata[7:0] & twm_pkg::CTRL_B_MASK;
      end else if (paddr == twm_pkg::OFF_CMP_A) begin
        compare_value_a <= pwdata[7:0];
      end else if (paddr == twm_pkg::OFF_CMP_B) begin
        compare_value_b <= pwdata[7:0];
      end else if (paddr == twm_pkg::OFF_PORT) begin
        port_ctl <= pwdata[3:0];
      end
    end
  end

  // live compare values: immediate outside PWM, else at the update point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_a <= twm_pkg::RST_CMP;
      live_b <= twm_pkg::RST_CMP;
    end else if (!is_pwm) begin
      live_a <= compare_value_a;
      live_b <= compare_value_b;
    end else if (upd_evt) begin
      live_a <= compare_value_a;
      live_b <= compare_value_b;
    end
  end

  // counter and direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= twm_pkg::BOTTOM_VAL;
      count_up <= 1'b1;
    end else if (tick) begin
      if (is_phase) begin
        if (count_up && at_top) begin
          count <= count - 8'h01;
          count_up <= 1'b0;
        end else if (!count_up && at_bot) begin
          count <= count + 8'h01;
          count_up <= 1'b1;
        end else if (count_up) begin
          count <= count + 8'h01;
        end else begin
          count <= count - 8'h01;
        end
      end else begin
        count <= at_top ? twm_pkg::BOTTOM_VAL : count + 8'h01;
        count_up <= 1'b1;
      end
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (tick && ovf_evt) begin
      overflow_flag <= 1'b1;
    end else if (wr && paddr == twm_pkg::OFF_STATUS && pwdata[twm_pkg::OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  // next level of one compare output; code 1 in PWM toggles only for
  // channel A with the high mode bit, channel B treats it as reserved
  function automatic logic oc_next(input logic cur, input logic [1:0] act,
    input logic match, input logic top_eq, input logic chan_a);
    logic r;
    r = cur;
    if (!is_pwm) begin
      if (match && act == 2'b01) begin
        r = !cur;
      end else if (match && act[1]) begin
        r = act[0];
      end
    end else if (act == 2'b01) begin
      if (chan_a && mode[2] && match) begin
        r = !cur;
      end
    end else if (act[1] && is_fast) begin
      if (match && !top_eq) begin
        r = act[0];
      end else if (at_bot) begin
        r = !act[0];
      end
    end else if (act[1]) begin
      if (top_eq) begin
        if (at_top) begin
          r = !act[0];
        end
      end else if (match) begin
        r = count_up ? act[0] : !act[0];
      end
    end
    return r;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_a <= 1'b0;
      oc_b <= 1'b0;
    end else if (tick) begin
      oc_a <= oc_next(oc_a, act_a, match_a, live_a == top, 1'b1);
      oc_b <= oc_next(oc_b, act_b, match_b, live_b == top, 1'b0);
    end
  end

  // compare output replaces the port data whenever an action is chosen
  // code 1 in PWM without the high mode bit leaves pin A to the port
  assign a_linked = (act_a != 2'b00) && !(is_pwm && act_a == 2'b01 && !mode[2]);
  assign pin_a_out = a_linked ? oc_a : port_ctl[twm_pkg::DATA_A_BIT];
  assign pin_b_out = (act_b != 2'b00) ? oc_b : port_ctl[twm_pkg::DATA_B_BIT];
  assign pin_a_oe = port_ctl[twm_pkg::DIR_A_BIT];
  assign pin_b_oe = port_ctl[twm_pkg::DIR_B_BIT];

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PIN_A_OVERRIDE: assert property (a_linked |-> pin_a_out == oc_a)
    else $error("pin A not driven by compare output");
  AST_PIN_A_PORT_OFF: assert property (!a_linked |-> pin_a_out == port_ctl[twm_pkg::DATA_A_BIT])
    else $error("pin A not left to port data");
  AST_PIN_B_OVERRIDE: assert property ((act_b != 2'b00) |-> pin_b_out == oc_b)
    else $error("pin B not driven by compare output");
  AST_OE_FOLLOWS_DIR: assert property (pin_a_oe == port_ctl[0] && pin_b_oe == port_ctl[1])
    else $error("pin enable differs from direction bit");
  AST_NONPWM_TOGGLE: assert property (!is_pwm && tick && act_a == 2'b01 && match_a
    |=> oc_a != $past(oc_a))
    else $error("non-PWM toggle missed");
  AST_PWM_CODE1_OFF: assert property (is_pwm && !mode[2] && act_a == 2'b01 |=> $stable(oc_a))
    else $error("PWM code 1 changed output with low mode bit");
  AST_FAST_BOTTOM_SET: assert property (is_fast && tick && act_a == 2'b10 && at_bot
    && live_a != twm_pkg::BOTTOM_VAL |=> oc_a)
    else $error("fast PWM did not set at bottom");
  AST_PHASE_UP_CLEAR: assert property (is_phase && tick && act_a == 2'b10 && count_up
    && match_a && live_a != top |=> !oc_a)
    else $error("phase PWM up match did not clear");
  AST_FAST_TOP_IGNORED: assert property (is_fast && tick && act_b[1] && live_b == top
    && match_b && !at_bot |=> $stable(oc_b))
    else $error("fast PWM match at TOP not ignored");
  AST_B_CODE1_RESERVED: assert property (is_pwm && act_b == 2'b01 |=> $stable(oc_b))
    else $error("channel B code 1 changed output in PWM");
  AST_RSV_READ_ZERO: assert property (control_a[3:2] == 2'b00)
    else $error("reserved control bits not zero");
  AST_NORMAL_OVF: assert property (mode == twm_pkg::MODE_NORMAL && tick
    && count == twm_pkg::MAX_VAL |=> overflow_flag && count == twm_pkg::BOTTOM_VAL)
    else $error("normal mode overflow wrong");
  AST_PHASE_RELOAD: assert property (is_phase && tick && at_top
    |=> live_a == $past(compare_value_a))
    else $error("phase PWM compare reload missed");
  AST_PHASE_DOWN_SET: assert property (is_phase && tick && act_a == 2'b10 && !count_up
    && match_a && live_a != top |=> oc_a)
    else $error("phase PWM down match did not set");
  AST_FAST_A_OVF_TOP: assert property (mode == twm_pkg::MODE_FAST_A && tick && at_top |=> overflow_flag)
    else $error("fast PWM overflow not set at TOP");
  AST_PHASE_OVF_BOTTOM: assert property (is_phase && tick && at_bot && !count_up |=> overflow_flag)
    else $error("phase PWM overflow not set at bottom");
endmodule

// ===== test/tb.sv
/*
  Self-checking bench for twm_core: APB registers, pin takeover and waveforms.
  Assumes twm_pkg and twm_core are compiled first; pready may wait.
*/
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, keep;
  logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
  int n_errors, n_compared, cycles, seed, ha, ea, hb, eb, r1, r2;

  twm_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic conclude;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ceiling well above the roughly 17k to 19k cycles the sequence needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // high cycles and edges of one pin over two periods; h < 0 means phase-dependent
  function automatic void model(input int md, act, c, ca, output int h, e, w);
    int top;
    int per;
    top = (md == 5 || md == 7) ? ca : 255;
    per = (md == 2) ? ca + 1 : (md == 1 || md == 5) ? 2 * top : top + 1;
    w = 2 * per;
    h = 0;
    if (act == 1 && (md == 0 || md == 2 || md >= 4)) h = -1;
    else if (act >= 2) begin
      if (md == 0 || md == 2) h = 0;
      else if (c >= top) h = w;
      else if (md == 3 || md == 7) h = 2 * c;
      else h = 4 * c;
      if (act == 3) h = w - h;
    end
    e = (h < 0) ? 2 : (h == 0 || h == w) ? 0 : 4;
  endfunction

  task automatic meas(input int n);
    logic pa;
    logic pb;
    ha = 0;
    ea = 0;
    hb = 0;
    eb = 0;
    #1;
    pa = pin_a_out;
    pb = pin_b_out;
    repeat (n) begin
      @(posedge pclk);
      #1;
      if (pin_a_out === 1'b1) ha++;
      if (pin_b_out === 1'b1) hb++;
      if (pin_a_out !== pa) ea++;
      if (pin_b_out !== pb) eb++;
      pa = pin_a_out;
      pb = pin_b_out;
    end
  endtask

  task automatic run_cfg(input int md, aa, ab, ca, cb);
    int h1, e1, h2, e2, w;
    apb(1'b1, twm_pkg::OFF_CMP_A, 32'(ca));
    apb(1'b1, twm_pkg::OFF_CMP_B, 32'(cb));
    apb(1'b1, twm_pkg::OFF_CTRL_A, 32'({aa[1:0], ab[1:0], 2'b00, md[1:0]}));
    apb(1'b1, twm_pkg::OFF_CTRL_B, 32'({md[2], 2'b00, 1'b1}));
    // long enough for a PWM compare reload at TOP and a counter above TOP to come back
    repeat (1200) @(posedge pclk);
    // cleared only once settled, so a wrap through MAX while switching is not counted
    apb(1'b1, twm_pkg::OFF_STATUS, 32'h0000_0100);
    model(md, aa, ca, ca, h1, e1, w);
    model(md, ab, cb, ca, h2, e2, w);
    // channel B code 1 in PWM takes the pin but holds its level
    if (ab == 1 && md % 2 == 1) begin
      h2 = -1;
      e2 = 0;
    end
    meas(w);
    if (h1 >= 0) chk(32'(ha), 32'(h1), "high a");
    chk(32'(ea), 32'(e1), "edges a");
    if (h2 >= 0) chk(32'(hb), 32'(h2), "high b");
    chk(32'(eb), 32'(e2), "edges b");
    apb(1'b0, twm_pkg::OFF_STATUS, 32'h0);
    chk(32'(rd[8]), 32'(md != 2), "overflow");
    if (md >= 5) chk(32'(rd[7:0] <= ca), 32'h1, "count above top");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 61163;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, twm_pkg::OFF_CTRL_A, 32'h0);
    chk(rd, 32'h0000_0000, "ctrl a reset");
    apb(1'b1, twm_pkg::OFF_CTRL_A, 32'hFFFF_FFFF);
    apb(1'b0, twm_pkg::OFF_CTRL_A, 32'h0);
    chk(rd, 32'h0000_00F3, "ctrl a readback");
    apb(1'b1, twm_pkg::OFF_CTRL_A, 32'h0);
    apb(1'b0, 8'hD0, 32'h0);
    chk({31'h0, last_err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, twm_pkg::OFF_PORT, 32'h0000_000D);
    #1;
    chk({28'h0, pin_a_oe, pin_b_oe, pin_a_out, pin_b_out}, 32'hB, "port pins");
    apb(1'b1, twm_pkg::OFF_PORT, 32'h0000_0003);
    #1;
    chk({30'h0, pin_a_oe, pin_b_oe}, 32'h3, "enables");
    r1 = 20 + ({$random(seed)} % 200);
    r2 = 10 + ({$random(seed)} % 200);
    run_cfg(0, 1, 2, r1, r2);
    run_cfg(0, 3, 1, r2, r1);
    run_cfg(2, 1, 3, r1, r1 / 2);
    run_cfg(3, 2, 3, r1, r2);
    run_cfg(3, 2, 2, 255, r2);
    run_cfg(1, 2, 3, r1, r2);
    run_cfg(1, 1, 2, r2, 255);
    run_cfg(5, 3, 2, r1, r1 / 2);
    run_cfg(7, 1, 3, r1, r1 / 2);
    run_cfg(7, 0, 1, r2, r1);
    // reserved mode: counter frozen, no new overflow
    apb(1'b1, twm_pkg::OFF_CTRL_A, 32'h0);
    apb(1'b1, twm_pkg::OFF_CTRL_B, 32'h0000_0009);
    apb(1'b1, twm_pkg::OFF_STATUS, 32'h0000_0100);
    apb(1'b0, twm_pkg::OFF_STATUS, 32'h0);
    keep = rd;
    repeat (300) @(posedge pclk);
    apb(1'b0, twm_pkg::OFF_STATUS, 32'h0);
    chk({24'h0, rd[7:0]}, {24'h0, keep[7:0]}, "held count");
    chk(32'(rd[8]), 32'h0, "held overflow");
    conclude();
  end
endmodule
